// [pwm_update_regs.vh]
// Register offsets, field positions and reset values of the PWM update control block.
`ifndef PWM_UPDATE_REGS_VH
`define PWM_UPDATE_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define UPD_ADDR_W 12
`define UPD_CFG_OFFSET 12'h10C
`define UPD_CFG_RESET 32'h00000055
`define UPD_CFG_USED_MASK 32'h000000FF

// ----------------------------------------------------------------
// Field positions in the configuration register
// ----------------------------------------------------------------
`define UPD_GLOBAL_EN_BIT 0
`define UPD_GLOBAL_FORCE_BIT 1
`define UPD_OP_EN_BIT(n) (2 + 2 * (n))
`define UPD_OP_FORCE_BIT(n) (3 + 2 * (n))

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define AHB_HTRANS_NONSEQ_BIT 1
`define AHB_HRESP_OKAY 1'h0

`endif

// [pwm_update_control.v]
// Update control for the working registers of the three PWM operators, with an AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_update_regs.vh"

// Overview of operation
// - Operator force bit toggle forces that operator's update.
// - Operator updates need operator and global enables set.
// - Global force bit toggle forces whole-unit update.
// - Global enable gates every update; operator enables gate only operator updates.

module pwm_update_control #(
	parameter NUM_OPS = 3
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire [NUM_OPS-1:0] op_update_event,
	output wire [NUM_OPS-1:0] op_update_strobe,
	output wire unit_update_strobe,
	output wire [NUM_OPS-1:0] op_update_allowed
);

	// ----------------------------------------------------------------
	// Bus address phase capture
	// ----------------------------------------------------------------
	reg wr_pending_reg;
	reg [`UPD_ADDR_W-1:0] wr_addr_reg;
	reg [31:0] cfg_reg;
	reg [31:0] hrdata_reg;
	reg hreadyout_reg;
	reg hresp_reg;

	wire addr_valid;
	wire rd_sel_cfg;
	wire wr_hits_cfg;
	reg [31:0] cfg_next;

	assign addr_valid = hsel & htrans[`AHB_HTRANS_NONSEQ_BIT] & hready;
	assign rd_sel_cfg = (haddr[`UPD_ADDR_W-1:0] == `UPD_CFG_OFFSET);
	assign wr_hits_cfg = wr_pending_reg & (wr_addr_reg == `UPD_CFG_OFFSET);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pending_reg <= 1'b0;
			wr_addr_reg <= {`UPD_ADDR_W{1'b0}};
			hreadyout_reg <= 1'b0;
			hresp_reg <= `AHB_HRESP_OKAY;
			hrdata_reg <= 32'h00000000;
		end
		else
		begin
			hreadyout_reg <= 1'b1;
			hresp_reg <= `AHB_HRESP_OKAY;
			if (hready)
			begin
				wr_pending_reg <= addr_valid & hwrite;
				wr_addr_reg <= haddr[`UPD_ADDR_W-1:0];
			end
			if (addr_valid & ~hwrite & rd_sel_cfg)
			begin
				// A write in its data phase this cycle is forwarded to the read.
				hrdata_reg <= cfg_next;
			end
			else
			begin
				hrdata_reg <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	always @*
	begin
		cfg_next = cfg_reg;
		if (wr_hits_cfg)
		begin
			cfg_next = hwdata & `UPD_CFG_USED_MASK;
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cfg_reg <= `UPD_CFG_RESET;
		end
		else
		begin
			cfg_reg <= cfg_next;
		end
	end

	// ----------------------------------------------------------------
	// Toggle detection and update strobes
	// ----------------------------------------------------------------
	wire global_en_next;
	wire global_force_toggle;
	wire [NUM_OPS-1:0] op_en_next;
	wire [NUM_OPS-1:0] op_force_toggle;
	wire [NUM_OPS-1:0] op_allowed_next;
	reg [NUM_OPS-1:0] op_update_strobe_reg;
	reg [NUM_OPS-1:0] op_update_allowed_reg;
	reg unit_update_strobe_reg;

	assign global_en_next = cfg_next[`UPD_GLOBAL_EN_BIT];
	// A changed bit in either direction gives one pulse; an equal rewrite gives none.
	assign global_force_toggle = cfg_next[`UPD_GLOBAL_FORCE_BIT]
		^ cfg_reg[`UPD_GLOBAL_FORCE_BIT];

	genvar i;
	generate
		for (i = 0; i < NUM_OPS; i = i + 1)
		begin : g_op
			assign op_en_next[i] = cfg_next[`UPD_OP_EN_BIT(i)];
			assign op_force_toggle[i] = cfg_next[`UPD_OP_FORCE_BIT(i)]
				^ cfg_reg[`UPD_OP_FORCE_BIT(i)];
			assign op_allowed_next[i] = op_en_next[i] & global_en_next;
		end
	endgenerate

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_update_strobe_reg <= {NUM_OPS{1'b0}};
			op_update_allowed_reg <= {NUM_OPS{1'b0}};
			unit_update_strobe_reg <= 1'b0;
		end
		else
		begin
			op_update_allowed_reg <= op_allowed_next;
			op_update_strobe_reg <= op_allowed_next
				& (op_update_event | op_force_toggle
				| {NUM_OPS{global_force_toggle}});
			unit_update_strobe_reg <= global_force_toggle & global_en_next;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign hrdata = hrdata_reg;
	assign op_update_strobe = op_update_strobe_reg;
	assign unit_update_strobe = unit_update_strobe_reg;
	assign op_update_allowed = op_update_allowed_reg;

endmodule // pwm_update_control

`default_nettype wire

// [pwm_update_checker_asserts.sv]
// Assertions on the PWM update control block.
`timescale 1ns/1ns
`default_nettype none
module pwm_update_checker #(parameter NUM_OPS = 3) (
	input wire hclk, input wire hresetn, input wire [1:0] htrans, input wire hwrite,
	input wire [NUM_OPS-1:0] op_update_event, input wire unit_update_strobe,
	input wire [NUM_OPS-1:0] op_update_strobe, input wire [NUM_OPS-1:0] op_update_allowed
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence wr_s; htrans[1] && hwrite; endsequence
	sequence force_s; wr_s ##2 unit_update_strobe; endsequence
	sequence ev_s; op_update_event[0] && op_update_allowed[0] && !hwrite; endsequence
	a_unit_cause: assert property (unit_update_strobe |-> $past(hwrite, 2))
		else $error("unit strobe without write");
	a_unit_all: assert property (unit_update_strobe |-> op_update_strobe == op_update_allowed)
		else $error("unit strobe misses operators");
	a_one_pulse: assert property (force_s |=> !unit_update_strobe)
		else $error("unit strobe too long");
	a_op_gated: assert property ((op_update_strobe & ~op_update_allowed) == '0)
		else $error("strobe while disabled");
	a_ev_load: assert property (ev_s |=> op_update_strobe[0])
		else $error("event not loaded");
endmodule // pwm_update_checker
bind pwm_update_control pwm_update_checker #(.NUM_OPS(NUM_OPS)) chk_u (.hclk, .hresetn,
	.htrans, .hwrite, .op_update_event, .unit_update_strobe, .op_update_strobe, .op_update_allowed);
`default_nettype wire

// [test_pwm_update_control.sv]
// Register-level bench for the PWM update control block.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_update_regs.vh"
module test_pwm_update_control;
	localparam logic [31:0] cfg_addr = `UPD_CFG_OFFSET;
	logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] op_update_event = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	wire hreadyout, hresp, unit_update_strobe;
	wire [2:0] op_update_strobe, op_update_allowed;
	wire [31:0] hrdata;
	int error_cnt = 0, check_count = 0;
	pwm_update_control dut_u (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.op_update_event, .op_update_strobe, .unit_update_strobe, .op_update_allowed);
	initial forever #4 hclk = ~hclk;
	task wrap_up;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task ck(input logic [31:0] a, input logic [31:0] e);
		check_count++;
		error_cnt += (a !== e);
		if (a !== e)
			$display("CHECK FAILED %0t got %h want %h", $time, a, e);
	endtask
	task wt;
		int n;
		@(posedge hclk);
		for (n = 0; n < 20 && hreadyout !== 1'h1; n++)
			@(posedge hclk);
		error_cnt += (n == 20);
		if (n == 20)
			$display("CHECK FAILED %0t no ready within 20 cycles", $time);
		if (n == 20)
			wrap_up;
	endtask
	// A write checks the strobes in the cycle after its data phase.
	task xf(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt;
		htrans <= 2'h0;
		hwdata <= d;
		#1 if (!w) ck(hrdata, e);
		if (!w) ck({31'h0, hresp}, 32'h0);
		wt;
		#1 if (w) ck({op_update_strobe, unit_update_strobe}, e);
		@(posedge hclk);
	endtask
	initial
	begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		xf(1'h0, cfg_addr, 32'h0, `UPD_CFG_RESET);
		xf(1'h0, 32'h200, 32'h0, 32'h0);
		xf(1'h1, cfg_addr, 32'h57, 32'hF);
		xf(1'h1, cfg_addr, 32'h57, 32'h0);
		xf(1'h1, cfg_addr, 32'h55, 32'hF);
		xf(1'h1, cfg_addr, 32'h5D, 32'h2);
		xf(1'h1, cfg_addr, 32'h6D, 32'h0);
		ck(op_update_allowed, 32'h5);
		xf(1'h1, cfg_addr, 32'h6C, 32'h0);
		xf(1'h1, cfg_addr, 32'h6E, 32'h0);
		xf(1'h1, cfg_addr, 32'h7F, 32'h0);
		xf(1'h1, cfg_addr, 32'hFF, 32'h8);
		xf(1'h0, cfg_addr, 32'h0, 32'hFF);
		op_update_event <= 3'h7;
		hwrite <= 1'h0;
		@(posedge hclk);
		#1 ck({op_update_strobe, unit_update_strobe}, 32'hE);
		wrap_up;
	end
endmodule // test_pwm_update_control
`default_nettype wire
